// ### inc/gwio_map.svh
/*
  Byte offsets, bit positions, sizes and timing counts of the three
  gateway I/O images. Assumes inclusion by bare name from the design files.
*/
`ifndef GWIO_MAP_SVH
`define GWIO_MAP_SVH

// ============================================================
// image layout
`define GWIO_WORD_BYTES      4
`define GWIO_IN_DATA_MAX     496
`define GWIO_OUT_DATA_MAX    492
`define GWIO_HDR_BYTES       4

// ============================================================
// status word bits
`define GWIO_ST_RUN          0
`define GWIO_ST_FAULT        1
`define GWIO_ST_NETDIS       2
`define GWIO_ST_COMMFAIL     3
`define GWIO_ST_VERIFY       4
`define GWIO_ST_BUSOFF       5
`define GWIO_ST_DUPADDR      6
`define GWIO_ST_NOPWR        7
`define GWIO_ST_USED         8

// ============================================================
// command word and run/idle header bits
`define GWIO_CMD_RUN         0
`define GWIO_CMD_FAULT       1
`define GWIO_CMD_NETDIS      2
`define GWIO_CMD_RESET       4
`define GWIO_HDR_SYSRUN      0

// ============================================================
// diagnostic image
`define GWIO_DG_TALLY_OFS    0
`define GWIO_DG_FAILED_OFS   4
`define GWIO_DG_WRONG_OFS    12
`define GWIO_DG_IDLE_OFS     20
`define GWIO_DG_SCANNED_OFS  28
`define GWIO_DG_BYTES        36
`define GWIO_DG_RESET        32'h0000_0000

// ============================================================
// timing
`define GWIO_REFRESH_MS      1000
`define GWIO_CLK_KHZ         100000
`define GWIO_REFRESH_CYCLES  (`GWIO_REFRESH_MS * `GWIO_CLK_KHZ)

`endif

// ### inc/gwio_pkg.sv
/*
  Types shared by the gateway I/O image mapper.
  Assumes the map header carries all numeric constants.
*/
`default_nettype none

package gwio_pkg;
  // output frame parser, gray along hdr -> cmd -> data -> drop
  typedef enum logic [1:0] {
    GWIO_RX_HDR  = 2'h0,
    GWIO_RX_CMD  = 2'h1,
    GWIO_RX_DATA = 2'h3,
    GWIO_RX_DROP = 2'h2
  } gwio_rx_state_t;
endpackage

`default_nettype wire

// ### rtl/gwio_diag.sv
/*
  Diagnostic image: scan tally and four node bitmaps, latched once per
  refresh period and read back byte-wise, least significant byte first.
  Assumes all inputs come from logic on mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gwio_map.svh"

module gwio_diag #(
  parameter int unsigned REFRESH_CYCLES = `GWIO_REFRESH_CYCLES
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  // live fieldbus state
  input  wire logic        scan_done_i,
  input  wire logic [63:0] failed_map_i,
  input  wire logic [63:0] wrong_map_i,
  input  wire logic [63:0] idle_map_i,
  input  wire logic [63:0] scanned_map_i,
  // byte read port
  input  wire logic [5:0]  rd_addr_i,
  output logic      [7:0]  rd_data_o
);

  // ============================================================
  // parameter check
  generate
    if (REFRESH_CYCLES < 2) begin : g_bad
      $error("refresh period too short");
    end
  endgenerate

  logic [31:0]  tick_cnt_q;
  logic         tick_q;
  logic [31:0]  tally_q;
  logic [287:0] snap_q;
  logic [63:0]  maps [4];

  assign maps[0] = failed_map_i;
  assign maps[1] = wrong_map_i;
  assign maps[2] = idle_map_i;
  assign maps[3] = scanned_map_i;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(REFRESH_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // live scan tally, wraps after 2^32 scans
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tally_q <= `GWIO_DG_RESET;
    end else if (scan_done_i) begin
      tally_q <= tally_q + 32'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      snap_q[`GWIO_DG_TALLY_OFS*8 +: 32] <= `GWIO_DG_RESET;
    end else if (tick_q) begin
      snap_q[`GWIO_DG_TALLY_OFS*8 +: 32] <= tally_q;
    end
  end

  // bitmaps at 4, 12, 20, 28, bit n is node n
  generate
    for (genvar m = 0; m < 4; m++) begin : g_map
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          snap_q[(`GWIO_DG_FAILED_OFS + 8*m)*8 +: 64] <= 64'h0;
        end else if (tick_q) begin
          snap_q[(`GWIO_DG_FAILED_OFS + 8*m)*8 +: 64] <= maps[m];
        end
      end
    end
  endgenerate

  // byte n of the flat image is bits 8n+7..8n, so lsb first
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_addr_i < 6'(`GWIO_DG_BYTES)) begin
      rd_data_o <= snap_q[rd_addr_i*8 +: 8];
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // ============================================================
  // assertions
  property p_refresh_spacing;
    @(posedge mclk_i) disable iff (!resetn_i)
      tick_q |=> !tick_q;
  endproperty
  a_refresh_spacing: assert property (p_refresh_spacing) else $error("refresh ticks too close");

  property p_le_low_byte;
    @(posedge mclk_i) disable iff (!resetn_i)
      (rd_addr_i == 6'h00) |=> (rd_data_o == $past(snap_q[7:0]));
  endproperty
  a_le_low_byte: assert property (p_le_low_byte) else $error("tally low byte not at offset 0");

  property p_snap_tally;
    @(posedge mclk_i) disable iff (!resetn_i)
      tick_q |=> (snap_q[31:0] == $past(tally_q));
  endproperty
  a_snap_tally: assert property (p_snap_tally) else $error("tally not latched on refresh");

endmodule

`default_nettype wire

// ### rtl/gwio_mapper.sv
/*
  Gateway I/O assembly mapper: input image (status word plus slave input
  table), output image parser (run/idle header, command word, slave output
  table) and diagnostic image. Assumes scanner and fieldbus master logic
  run on mclk_i; only the fieldbus power sense is an asynchronous pin.
*/
// Behaviour
// - status word, then up to 496 input bytes
// - unconfigured input bytes read as zero
// - status bit 0 shows run mode
// - bits 1-3: fault, net disabled, comm failure
// - bit 4 verify failure, bit 5 bus-off
// - bit 6 duplicate address, bit 7 no power
// - command word, then up to 492 output bytes
// - output bytes past configured size ignored
// - strip 4-byte run/idle header first
// - run needs command bit 0 and sysrun
// - command bit 1 faults, bit 2 disables
// - command bit 4 resets, others ignored
// - diagnostic image refreshed every second
// - diagnostic values stored little-endian
// - bytes 0-3 hold scan tally
// - fault, wrong-type, idle bitmaps at 4,12,20
// - scanned-node bitmap at offset 28
// - oversized connection reads zero beyond data
`timescale 1ns/1ps
`default_nettype none
`include "gwio_map.svh"

module gwio_mapper #(
  parameter int unsigned IN_DATA_MAX    = `GWIO_IN_DATA_MAX,
  parameter int unsigned OUT_DATA_MAX   = `GWIO_OUT_DATA_MAX,
  parameter int unsigned REFRESH_CYCLES = `GWIO_REFRESH_CYCLES
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  // configured slave data sizes in bytes
  input  wire logic [8:0]  in_cfg_size_i,
  input  wire logic [8:0]  out_cfg_size_i,
  // fieldbus master condition
  input  wire logic        gw_fault_i,
  input  wire logic        net_off_i,
  input  wire logic        bus_off_i,
  input  wire logic        dup_addr_i,
  input  wire logic        no_power_pin_i,
  input  wire logic        scan_done_i,
  input  wire logic [63:0] failed_map_i,
  input  wire logic [63:0] wrong_map_i,
  input  wire logic [63:0] idle_map_i,
  input  wire logic [63:0] scanned_map_i,
  // slave input table write
  input  wire logic        in_wr_en_i,
  input  wire logic [8:0]  in_wr_addr_i,
  input  wire logic [7:0]  in_wr_data_i,
  // scanner input image read
  input  wire logic [8:0]  in_rd_addr_i,
  output logic      [7:0]  in_rd_data_o,
  // scanner output frame
  input  wire logic        out_sof_i,
  input  wire logic        out_wr_en_i,
  input  wire logic [7:0]  out_wr_data_i,
  input  wire logic        out_eof_i,
  // slave output table read
  input  wire logic [8:0]  out_rd_addr_i,
  output logic      [7:0]  out_rd_data_o,
  // diagnostic image read
  input  wire logic [5:0]  diag_rd_addr_i,
  output logic      [7:0]  diag_rd_data_o,
  // gateway control and status
  output logic             run_o,
  output logic             fault_o,
  output logic             net_disable_o,
  output logic             module_reset_o,
  output logic      [31:0] status_word_o
);

  // ============================================================
  // parameter check
  generate
    if (IN_DATA_MAX < 1 || IN_DATA_MAX > `GWIO_IN_DATA_MAX ||
        OUT_DATA_MAX < 1 || OUT_DATA_MAX > `GWIO_OUT_DATA_MAX) begin : g_bad
      $error("table sizes out of range");
    end
  endgenerate

  localparam logic [8:0] IN_MAX9  = 9'(IN_DATA_MAX);
  localparam logic [8:0] OUT_MAX9 = 9'(OUT_DATA_MAX);
  localparam logic [8:0] WORD9    = 9'(`GWIO_WORD_BYTES);
  localparam logic [1:0] LAST_B   = 2'(`GWIO_HDR_BYTES - 1);

  // ============================================================
  // storage and state
  logic [7:0]              in_mem  [IN_DATA_MAX];
  logic [7:0]              out_mem [OUT_DATA_MAX];
  logic [1:0]              no_pwr_sync_q;
  gwio_pkg::gwio_rx_state_t rx_state_q;
  logic [8:0]              rx_cnt_q;
  logic [31:0]             hdr_sh_q;
  logic [31:0]             cmd_sh_q;
  logic                    commit;
  logic                    out_we;
  logic [8:0]              in_idx;

  // power sense comes straight from a pin
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      no_pwr_sync_q <= 2'b00;
    end else begin
      no_pwr_sync_q <= {no_pwr_sync_q[0], no_power_pin_i};
    end
  end

  // ============================================================
  // input table, written as slave input connections arrive
  always_ff @(posedge mclk_i) begin
    if (in_wr_en_i && in_wr_addr_i < IN_MAX9) begin
      in_mem[in_wr_addr_i] <= in_wr_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_word_o <= 32'h0;
    end else begin
      status_word_o                    <= 32'h0; // spare bits
      status_word_o[`GWIO_ST_RUN]      <= run_o;
      status_word_o[`GWIO_ST_FAULT]    <= fault_o | gw_fault_i;
      status_word_o[`GWIO_ST_NETDIS]   <= net_disable_o | net_off_i;
      status_word_o[`GWIO_ST_COMMFAIL] <= |failed_map_i;
      status_word_o[`GWIO_ST_VERIFY]   <= |wrong_map_i;
      status_word_o[`GWIO_ST_BUSOFF]   <= bus_off_i;
      status_word_o[`GWIO_ST_DUPADDR]  <= dup_addr_i;
      status_word_o[`GWIO_ST_NOPWR]    <= no_pwr_sync_q[1];
    end
  end

  assign in_idx = in_rd_addr_i - WORD9;

  // status word first, data from byte 4, one cycle latency
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_rd_data_o <= 8'h00;
    end else if (in_rd_addr_i < WORD9) begin
      in_rd_data_o <= status_word_o[in_rd_addr_i[1:0]*8 +: 8];
    end else if (in_idx < in_cfg_size_i && in_idx < IN_MAX9) begin
      in_rd_data_o <= in_mem[in_idx];
    end else begin
      in_rd_data_o <= 8'h00;
    end
  end

  // ============================================================
  // output frame parser; sof resets, eof commits the command word.
  // a frame shorter than header plus command changes nothing.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_state_q <= gwio_pkg::GWIO_RX_HDR;
      rx_cnt_q   <= 9'h0;
    end else if (out_sof_i) begin
      rx_state_q <= gwio_pkg::GWIO_RX_HDR;
      rx_cnt_q   <= 9'h0;
    end else if (out_wr_en_i) begin
      unique case (rx_state_q)
        // four header bytes before the command
        gwio_pkg::GWIO_RX_HDR: begin
          rx_cnt_q <= (rx_cnt_q[1:0] == LAST_B) ? 9'h0 : rx_cnt_q + 9'h1;
          if (rx_cnt_q[1:0] == LAST_B) begin
            rx_state_q <= gwio_pkg::GWIO_RX_CMD;
          end
        end
        // command word then slave output data
        gwio_pkg::GWIO_RX_CMD: begin
          rx_cnt_q <= (rx_cnt_q[1:0] == LAST_B) ? 9'h0 : rx_cnt_q + 9'h1;
          if (rx_cnt_q[1:0] == LAST_B) begin
            rx_state_q <= gwio_pkg::GWIO_RX_DATA;
          end
        end
        gwio_pkg::GWIO_RX_DATA: begin
          rx_cnt_q <= rx_cnt_q + 9'h1;
          if (rx_cnt_q + 9'h1 >= out_cfg_size_i || rx_cnt_q + 9'h1 >= OUT_MAX9) begin
            rx_state_q <= gwio_pkg::GWIO_RX_DROP;
          end
        end
        gwio_pkg::GWIO_RX_DROP: begin
          rx_cnt_q <= rx_cnt_q;
        end
      endcase
    end
  end

  // header and command bytes arrive lsb first
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hdr_sh_q <= 32'h0;
      cmd_sh_q <= 32'h0;
    end else if (out_wr_en_i && !out_sof_i && rx_state_q == gwio_pkg::GWIO_RX_HDR) begin
      hdr_sh_q[rx_cnt_q[1:0]*8 +: 8] <= out_wr_data_i;
    end else if (out_wr_en_i && !out_sof_i && rx_state_q == gwio_pkg::GWIO_RX_CMD) begin
      cmd_sh_q[rx_cnt_q[1:0]*8 +: 8] <= out_wr_data_i;
    end
  end

  // data goes to the table only inside the configured size
  assign out_we = out_wr_en_i && !out_sof_i && rx_state_q == gwio_pkg::GWIO_RX_DATA &&
                  out_cfg_size_i != 9'h0;

  // no staging: the fieldbus side always sees the latest write
  always_ff @(posedge mclk_i) begin
    if (out_we) begin
      out_mem[rx_cnt_q] <= out_wr_data_i;
    end
  end

  // slave output table read, one cycle latency
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_rd_data_o <= 8'h00;
    end else if (out_rd_addr_i < out_cfg_size_i && out_rd_addr_i < OUT_MAX9) begin
      out_rd_data_o <= out_mem[out_rd_addr_i];
    end else begin
      out_rd_data_o <= 8'h00;
    end
  end

  // a command takes effect only once the whole word has arrived
  assign commit = out_eof_i && !out_sof_i &&
                  (rx_state_q == gwio_pkg::GWIO_RX_DATA || rx_state_q == gwio_pkg::GWIO_RX_DROP);

  // ============================================================
  // command effects; bits 3 and 5..31 are never looked at
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_o         <= 1'b0;
      fault_o       <= 1'b0;
      net_disable_o <= 1'b0;
    end else if (commit) begin
      run_o         <= cmd_sh_q[`GWIO_CMD_RUN] & hdr_sh_q[`GWIO_HDR_SYSRUN];
      fault_o       <= cmd_sh_q[`GWIO_CMD_FAULT];
      net_disable_o <= cmd_sh_q[`GWIO_CMD_NETDIS];
    end
  end

  // reset pulse, one cycle per command
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      module_reset_o <= 1'b0;
    end else begin
      module_reset_o <= commit & cmd_sh_q[`GWIO_CMD_RESET] & !module_reset_o;
    end
  end

  // ============================================================
  // diagnostic image
  // latched once per refresh period
  gwio_diag #(
    .REFRESH_CYCLES (REFRESH_CYCLES)
  ) u_diag (
    .mclk_i        (mclk_i),
    .resetn_i      (resetn_i),
    .scan_done_i   (scan_done_i),
    .failed_map_i  (failed_map_i),
    .wrong_map_i   (wrong_map_i),
    .idle_map_i    (idle_map_i),
    .scanned_map_i (scanned_map_i),
    .rd_addr_i     (diag_rd_addr_i),
    .rd_data_o     (diag_rd_data_o)
  );

  // ============================================================
  // assertions
  sequence s_commit_run;
    commit && cmd_sh_q[`GWIO_CMD_RUN] && hdr_sh_q[`GWIO_HDR_SYSRUN];
  endsequence

  sequence s_commit_idle;
    commit && !(cmd_sh_q[`GWIO_CMD_RUN] && hdr_sh_q[`GWIO_HDR_SYSRUN]);
  endsequence

  property p_run_both;
    @(posedge mclk_i) disable iff (!resetn_i)
      s_commit_run |=> run_o ##1 status_word_o[`GWIO_ST_RUN];
  endproperty
  a_run_both: assert property (p_run_both) else $error("run not entered");

  property p_idle_else;
    @(posedge mclk_i) disable iff (!resetn_i)
      s_commit_idle |=> !run_o ##1 !status_word_o[`GWIO_ST_RUN];
  endproperty
  a_idle_else: assert property (p_idle_else) else $error("run without both bits");

  property p_spare_zero;
    @(posedge mclk_i) disable iff (!resetn_i)
      status_word_o[31:`GWIO_ST_USED] == 24'h0;
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("spare status bits set");

  property p_status_byte0;
    @(posedge mclk_i) disable iff (!resetn_i)
      (in_rd_addr_i == 9'h0) |=> (in_rd_data_o == $past(status_word_o[7:0]));
  endproperty
  a_status_byte0: assert property (p_status_byte0) else $error("status not at byte 0");

  property p_pad_zero;
    @(posedge mclk_i) disable iff (!resetn_i)
      (in_rd_addr_i >= WORD9 && in_idx >= in_cfg_size_i) |=> (in_rd_data_o == 8'h00);
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("padding byte not zero");

  property p_drop_extra;
    @(posedge mclk_i) disable iff (!resetn_i)
      out_we |-> (rx_cnt_q < out_cfg_size_i && rx_cnt_q < OUT_MAX9);
  endproperty
  a_drop_extra: assert property (p_drop_extra) else $error("excess output byte stored");

  property p_hdr_strip;
    @(posedge mclk_i) disable iff (!resetn_i)
      (rx_state_q == gwio_pkg::GWIO_RX_CMD && $past(rx_state_q) == gwio_pkg::GWIO_RX_HDR)
      |-> ($past(rx_cnt_q) == 9'h3 && rx_cnt_q == 9'h0);
  endproperty
  a_hdr_strip: assert property (p_hdr_strip) else $error("header not four bytes");

  property p_fault_cmd;
    @(posedge mclk_i) disable iff (!resetn_i)
      (commit && cmd_sh_q[`GWIO_CMD_FAULT]) |=> fault_o ##1 status_word_o[`GWIO_ST_FAULT];
  endproperty
  a_fault_cmd: assert property (p_fault_cmd) else $error("fault command not shown");

  property p_reset_pulse;
    @(posedge mclk_i) disable iff (!resetn_i)
      module_reset_o |-> $past(commit) && $past(cmd_sh_q[`GWIO_CMD_RESET]) ##1 !module_reset_o;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse malformed");

  property p_busoff;
    @(posedge mclk_i) disable iff (!resetn_i)
      bus_off_i |=> status_word_o[`GWIO_ST_BUSOFF];
  endproperty
  a_busoff: assert property (p_busoff) else $error("bus-off not flagged");

  property p_dup_addr;
    @(posedge mclk_i) disable iff (!resetn_i)
      dup_addr_i |=> status_word_o[`GWIO_ST_DUPADDR];
  endproperty
  a_dup_addr: assert property (p_dup_addr) else $error("duplicate address not flagged");

  property p_comm_fail;
    @(posedge mclk_i) disable iff (!resetn_i)
      (|failed_map_i) |=> status_word_o[`GWIO_ST_COMMFAIL];
  endproperty
  a_comm_fail: assert property (p_comm_fail) else $error("comm failure not flagged");

  property p_out_first;
    @(posedge mclk_i) disable iff (!resetn_i)
      (rx_state_q == gwio_pkg::GWIO_RX_DATA && $past(rx_state_q) == gwio_pkg::GWIO_RX_CMD)
      |-> rx_cnt_q == 9'h0;
  endproperty
  a_out_first: assert property (p_out_first) else $error("data does not start after command");

endmodule

`default_nettype wire

// ### dv/gwio_scanner.sv
/*
  Scanner model: sends output frames (header, command, data) to the mapper.
  Assumes the bench calls send and mclk_i is the mapper clock.
*/
`timescale 1ns/1ps
`default_nettype none

module gwio_scanner (
  // clock
  input  wire logic       mclk_i,
  // output frame
  output logic            sof_o,
  output logic            wr_en_o,
  output logic      [7:0] wr_data_o,
  output logic            eof_o
);
  // ====
  // quiet frame port at time zero
  initial begin
    sof_o = 1'b0;
    wr_en_o = 1'b0;
    wr_data_o = 8'h00;
    eof_o = 1'b0;
  end

  task automatic send(input logic [31:0] hdr, input logic [31:0] cmd, input int cut);
    logic [63:0] w;
    w = {cmd, hdr};
    @(negedge mclk_i);
    sof_o <= 1'b1;
    for (int i = 0; i < cut; i++) begin
      @(negedge mclk_i);
      sof_o <= 1'b0;
      wr_en_o <= 1'b1;
      wr_data_o <= (i < 8) ? w[8*i+:8] : 8'h10 + 8'(i - 8);
    end
    @(negedge mclk_i);
    sof_o <= 1'b0;
    wr_en_o <= 1'b0;
    // released line flips, so no stale byte passes
    wr_data_o <= ~wr_data_o;
    eof_o <= 1'b1;
    @(negedge mclk_i);
    eof_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ### dv/testbench.sv
/*
  Bench for gwio_mapper: status rows, frame rows, tables, diag, reset.
  Assumes gwio_scanner drives the output frame port.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ====
  // signals
  logic         mclk = 1'b0, resetn = 1'b0, gflt = 1'b0, noff = 1'b0, wen = 1'b0;
  logic         boff = 1'b0, dup = 1'b0, npwr = 1'b0, scan = 1'b0;
  logic [8:0]   in_sz = 9'h000, out_sz = 9'h000, wa = 9'h000, ra = 9'h000;
  logic [7:0]   wd = 8'h00, in_rd, out_rd, dg_rd, owd, d;
  logic [63:0]  fm = 64'h0, wm = 64'h0, im = 64'h0, sm = 64'h0;
  logic         sof, owe, eof, run, flt, nd, mrst;
  logic [31:0]  st;
  logic [287:0] dv;
  int           n_fail = 0, n_compared = 0, cyc = 0;
  typedef struct packed { logic [6:0] c; logic [31:0] s; } gwio_st_row_t;
  typedef struct packed { logic [31:0] h, m; logic [3:0] e; } gwio_fr_row_t;
  // conditions {nopwr,dup,busoff,wrong,failed,netoff,fault}
  gwio_st_row_t st_rows [9] = '{'{7'h01, 32'h02}, '{7'h02, 32'h04}, '{7'h04, 32'h08},
    '{7'h08, 32'h10}, '{7'h10, 32'h20}, '{7'h20, 32'h40}, '{7'h40, 32'h80},
    '{7'h7f, 32'hfe}, '{7'h00, 32'h00}};
  // expect {reset pulse, net disable, fault, run}
  gwio_fr_row_t fr_rows [7] = '{'{32'h1, 32'h1, 4'h1}, '{32'hffff_fffe, 32'h1, 4'h0},
    '{32'h1, 32'h0, 4'h0}, '{32'h1, 32'h2, 4'h2}, '{32'h1, 32'h4, 4'h4},
    '{32'h1, 32'hffff_ffe9, 4'h1}, '{32'h1, 32'h10, 4'h8}};

  // ====
  // design and scanner
  gwio_mapper #(.REFRESH_CYCLES(20)) u_dut (.mclk_i(mclk), .resetn_i(resetn),
    .in_cfg_size_i(in_sz), .out_cfg_size_i(out_sz), .gw_fault_i(gflt), .net_off_i(noff),
    .bus_off_i(boff), .dup_addr_i(dup), .no_power_pin_i(npwr), .scan_done_i(scan),
    .failed_map_i(fm), .wrong_map_i(wm), .idle_map_i(im), .scanned_map_i(sm),
    .in_wr_en_i(wen), .in_wr_addr_i(wa), .in_wr_data_i(wd), .in_rd_addr_i(ra),
    .in_rd_data_o(in_rd), .out_sof_i(sof), .out_wr_en_i(owe), .out_wr_data_i(owd),
    .out_eof_i(eof), .out_rd_addr_i(ra), .out_rd_data_o(out_rd), .diag_rd_addr_i(ra[5:0]),
    .diag_rd_data_o(dg_rd), .run_o(run), .fault_o(flt), .net_disable_o(nd),
    .module_reset_o(mrst), .status_word_o(st));
  gwio_scanner u_scan (.mclk_i(mclk), .sof_o(sof), .wr_en_o(owe), .wr_data_o(owd), .eof_o(eof));

  // ====
  // clock and hang guard, a run needs about 330 cycles
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ====
  // helpers
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one shared read address; answer lands one cycle later
  task automatic rd(input int sel, input logic [8:0] a, output logic [7:0] q);
    @(negedge mclk);
    ra = a;
    @(negedge mclk);
    q = (sel == 0) ? in_rd : (sel == 1) ? out_rd : dg_rd;
  endtask
  task automatic end_of_test();
    $display("counts: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ====
  // main sequence
  initial begin
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    chk("status after reset", st, 32'h0);
    // status rows; sync of the power pin needs three edges
    foreach (st_rows[i]) begin
      {npwr, dup, boff} = st_rows[i].c[6:4];
      wm = {63'h0, st_rows[i].c[3]} << 9;
      fm = {63'h0, st_rows[i].c[2]} << 40;
      {noff, gflt} = st_rows[i].c[1:0];
      repeat (4) @(negedge mclk);
      chk("status word", st, st_rows[i].s);
    end
    $display("test status rows done");
    // frame rows
    foreach (fr_rows[i]) begin
      u_scan.send(fr_rows[i].h, fr_rows[i].m, 8);
      chk("controls", {mrst, nd, flt, run}, fr_rows[i].e);
      @(negedge mclk);
      chk("reset pulse end", mrst, 1'b0);
      chk("status low bits", st, {29'h0, fr_rows[i].e[2:0]});
    end
    $display("test frame rows done");
    // short frame must not undo a running commit
    u_scan.send(32'h1, 32'h1, 8);
    u_scan.send(32'h1, 32'h0, 6);
    chk("run kept", run, 1'b1);
    // bytes past the configured size dropped
    out_sz = 9'h003;
    u_scan.send(32'h1, 32'h1, 13);
    for (int k = 0; k < 5; k++) begin
      rd(1, k[8:0], d);
      chk("output table", d, (k < 3) ? 8'h10 + k[7:0] : 8'h00);
    end
    $display("test output table done");
    // input table: two configured bytes, third write unseen
    in_sz = 9'h002;
    gflt = 1'b1;
    dup = 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(negedge mclk);
      wen = 1'b1;
      wa = k[8:0];
      wd = 8'ha5 ^ k[7:0];
    end
    @(negedge mclk);
    wen = 1'b0;
    for (int k = 0; k < 7; k++) begin
      rd(0, k[8:0], d);
      chk("input image", d, (k == 0) ? 8'h43 : (k == 4 || k == 5) ? 8'ha5 ^ (k[7:0] - 8'h4) : 8'h00);
    end
    $display("test input image done");
    // diagnostic snapshot after three scans
    gflt = 1'b0;
    dup = 1'b0;
    fm = 64'h8877_6655_4433_2211;
    wm = ~fm;
    im = {fm[31:0], fm[63:32]};
    sm = 64'h0123_4567_89ab_cdef;
    repeat (3) begin
      @(negedge mclk);
      scan = 1'b1;
      @(negedge mclk);
      scan = 1'b0;
    end
    repeat (30) @(negedge mclk);
    dv = {sm, im, wm, fm, 32'h3};
    for (int k = 0; k < 37; k++) begin
      rd(2, k[8:0], d);
      chk("diag byte", d, (k < 36) ? dv[8*k+:8] : 8'h00);
    end
    $display("test diagnostic done");
    // second reset in mid-run
    resetn = 1'b0;
    @(negedge mclk);
    chk("run in reset", run, 1'b0);
    chk("status in reset", st, 32'h0);
    resetn = 1'b1;
    rd(2, 9'h004, d);
    chk("diag before tick", d, 8'h00);
    repeat (25) @(negedge mclk);
    rd(2, 9'h004, d);
    chk("diag after tick", d, 8'h11);
    $display("test reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
